// ===== src/hcpp_consts.svh
// constants for the host cpu parallel port: flag bits, type codes, addresses
`ifndef HCPP_CONSTS_SVH
`define HCPP_CONSTS_SVH

// flag port bit positions
`define HCPP_FLAG_STAT_BIT 0
`define HCPP_FLAG_RDAT_BIT 1
`define HCPP_FLAG_CMD_BIT 2
`define HCPP_FLAG_WDAT_BIT 3
`define HCPP_FLAG_RXEN_BIT 4
`define HCPP_FLAG_UNUSED 3'h0

// port select address bits
`define HCPP_ADDR_FLAG_BIT 2
`define HCPP_ADDR_DATA_BIT 1
`define HCPP_ADDR_BYTE_BIT 0

// host interface type codes
`define HCPP_TYPE_0 3'h0
`define HCPP_TYPE_1 3'h1
`define HCPP_TYPE_2 3'h2
`define HCPP_TYPE_3 3'h3
`define HCPP_TYPE_RSVD 3'h4
`define HCPP_TYPE_5 3'h5
`define HCPP_TYPE_6 3'h6
`define HCPP_TYPE_STORED 3'h7

// byte pairing masks
`define HCPP_GOT_LO 2'h1
`define HCPP_GOT_HI 2'h2
`define HCPP_GOT_BOTH 2'h3

// synchroniser width: select, two read strobes, two write strobes
`define HCPP_SYNC_W 5

`endif

// ===== src/hcpp_pkg.sv
// types shared by the host cpu parallel port modules
package hcpp_pkg;

	// port reached by one host access
	typedef enum logic [1:0] {
		HCPP_PORT_NONE,
		HCPP_PORT_CMD,
		HCPP_PORT_DATA,
		HCPP_PORT_FLAG
	} hcpp_port_e;

	// whole state of the port top
	typedef struct packed {
		logic straps_taken;
		logic mux_mode;
		logic big_endian;
		logic narrow;
		logic irq_pol;
		logic absent;
		logic [2:0] itype;
		logic act;
		logic latch_prev;
		logic [2:0] mux_addr;
		logic [15:0] cmd_word;
		logic [1:0] cmd_got;
		logic [15:0] wdat_word;
		logic [1:0] wdat_got;
		logic [1:0] stat_got;
		logic [1:0] rdat_got;
		logic [15:0] status_word;
		logic [15:0] rdata_word;
		logic fl_cmd;
		logic fl_wdat;
		logic fl_rdat;
		logic fl_stat;
		logic [15:0] dout;
		logic doe;
		logic irq;
		logic irq_oe;
	} hcpp_state_s;

	// state of the strobe synchroniser
	typedef struct packed {
		logic [4:0] first;
		logic [4:0] second;
	} hcpp_sync_s;

endpackage : hcpp_pkg

// ===== src/hcpp_sync.sv
// two-flop synchroniser for the host select and strobe pins
`timescale 1ns/1ps
`default_nettype none

module hcpp_sync (
	// clock, reset, enable
	input wire logic clk_sys_i,
	input wire logic rstn_i,
	input wire logic clk_en_i,
	// strobes in and out
	hcpp_sync_if.snk sync_if
);
	import hcpp_pkg::*;

	hcpp_sync_s st_q;
	hcpp_sync_s st_d;

	// first stage feeds only the second stage
	always_comb begin
		st_d = st_q;
		if (clk_en_i) begin
			st_d.first = sync_if.raw;
			st_d.second = st_q.first;
		end
	end

	// idle strobes are high, so reset to all ones
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			st_q <= {5'h1f, 5'h1f};
		end else begin
			st_q <= st_d;
		end
	end

	assign sync_if.synced = st_q.second;

endmodule : hcpp_sync

`default_nettype wire

// ===== src/hcpp_sync_if.sv
// carrier for raw and synchronised host strobes
`timescale 1ns/1ps
`default_nettype none

interface hcpp_sync_if;
	logic [4:0] raw;
	logic [4:0] synced;

	// top drives raw strobes and reads synced ones
	modport src (output raw, input synced);
	// synchroniser takes raw and returns synced
	modport snk (input raw, output synced);
endinterface : hcpp_sync_if

`default_nettype wire

// ===== src/hcpp_top.sv
// host cpu parallel port: strobe decode, ports, flags and host interrupt
// Summary of operation
// - accesses count only while host select is low
// - wide bus: LLL command/status, LHL data, Hxx flag port
// - narrow bus: LLL/LLH command/status bytes, LHL/LHH data bytes, Hxx flags
// - narrow bus: a word completes once both bytes are accessed, any order
// - wide bus: flag byte driven on both byte lanes
// - flag port is one byte; both narrow byte addresses read it
// - flag bits 7 to 5 read zero
// - flag bit 4 shows data receive circuit enabled
// - flag bit 3 set while written data waits for the core
// - flag bit 2 set while a written command waits for the core
// - flag bit 1 set when read data ready, cleared by host read
// - flag bit 0 set when status ready, cleared by status read
// - interrupt active while flag bit 1 or 0 is set
// - interrupt pin tri-state, polarity from strap taken after reset
// - multiplex strap low selects multiplexed address/data bus, except with types 3 and 6
// - byte order strap low little-endian, high big-endian
// - width strap low selects 16-bit, high selects 8-bit bus
// - command and status ports are 16 bits, two bytes on narrow bus
// - data port carries payload and option segments both ways
// - wide bus: flag port accepts no writes, lower and upper lanes alike
// - read and write strobes decoded per selected interface type
// - type select 000-110 picks type, 111 uses stored type or absent
// - multiplexed bus latches data bits 2:0 as port address
`timescale 1ns/1ps
`default_nettype none
`include "hcpp_consts.svh"

module hcpp_top (
	// clock, reset, enable
	input wire logic clk_sys_i,
	input wire logic rstn_i,
	input wire logic clk_en_i,
	// host bus pins
	input wire logic host_select_n_i,
	input wire logic [2:0] port_select_i,
	input wire logic [15:0] host_data_bus_i,
	output logic [15:0] host_data_bus_o,
	output logic host_data_bus_oe_o,
	input wire logic read_strobe_a_n_i,
	input wire logic read_strobe_b_n_i,
	input wire logic write_strobe_a_n_i,
	input wire logic write_strobe_b_n_i,
	output logic host_irq_o,
	output logic host_irq_oe_o,
	// straps and type selection, taken after reset
	input wire logic [2:0] iface_type_sel_i,
	input wire logic [2:0] stored_iface_type_i,
	input wire logic bus_multiplex_strap_i,
	input wire logic irq_polarity_strap_i,
	input wire logic byte_order_strap_i,
	input wire logic bus_width_strap_i,
	// core side: commands and written data
	output logic [15:0] cmd_word_o,
	output logic command_pending_o,
	input wire logic cmd_taken_i,
	output logic [15:0] wdata_word_o,
	output logic write_data_pending_o,
	input wire logic wdata_taken_i,
	// core side: status and read data
	input wire logic [15:0] status_word_i,
	input wire logic status_load_i,
	input wire logic [15:0] rdata_word_i,
	input wire logic rdata_load_i,
	input wire logic data_rx_enabled_i,
	output logic host_absent_o
);
	import hcpp_pkg::*;

	hcpp_state_s st_q;
	hcpp_state_s st_d;
	hcpp_sync_if sync_if ();

	// raw pin order: select, read a, read b, write a, write b
	assign sync_if.raw = {host_select_n_i, read_strobe_a_n_i,
		read_strobe_b_n_i, write_strobe_a_n_i, write_strobe_b_n_i};

	hcpp_sync u_sync (
		.clk_sys_i(clk_sys_i),
		.rstn_i(rstn_i),
		.clk_en_i(clk_en_i),
		.sync_if(sync_if)
	);

	logic sel_n;
	logic rda_n;
	logic rdb_n;
	logic wra_n;
	logic wrb_n;
	assign {sel_n, rda_n, rdb_n, wra_n, wrb_n} = sync_if.synced;

	// byte swap used for big-endian word transfers
	function automatic logic [15:0] swap16(input logic [15:0] w,
		input logic en);
		swap16 = en ? {w[7:0], w[15:8]} : w;
	endfunction : swap16

	// decoded strobe meaning
	logic rd;
	logic wr;
	logic lane_lo;
	logic lane_hi;
	logic latch;

	// strobe decode per interface type
	always_comb begin
		rd = 1'b0;
		wr = 1'b0;
		lane_lo = 1'b1;
		lane_hi = 1'b1;
		latch = 1'b0;
		case (st_q.itype)
			`HCPP_TYPE_0: begin
				rd = ~rda_n;
				wr = ~wra_n | ~wrb_n;
				lane_lo = ~wra_n | ~rda_n;
				lane_hi = ~wrb_n | ~rda_n;
				latch = rdb_n;
			end
			`HCPP_TYPE_1: begin
				// data strobes qualify, read/write level picks direction
				rd = (~wra_n | ~wrb_n) & ~rdb_n ? 1'b0 : (~wra_n | ~wrb_n);
				wr = (~wra_n | ~wrb_n) & ~rdb_n;
				lane_hi = ~wra_n;
				lane_lo = ~wrb_n;
				latch = rda_n;
			end
			`HCPP_TYPE_2: begin
				// no data strobe here, select alone frames the access
				rd = rdb_n;
				wr = ~rdb_n;
				latch = wrb_n;
			end
			`HCPP_TYPE_3: begin
				rd = ~rda_n | ~rdb_n;
				wr = ~wra_n | ~wrb_n;
				lane_lo = ~wra_n | ~rda_n;
				lane_hi = ~wrb_n | ~rdb_n;
			end
			`HCPP_TYPE_5: begin
				rd = ~rda_n;
				wr = ~wra_n;
				lane_hi = ~wrb_n;
				latch = rdb_n;
			end
			`HCPP_TYPE_6: begin
				rd = ~rda_n;
				wr = ~wra_n;
				lane_lo = ~rdb_n;
			end
			default: begin
				rd = 1'b0;
				wr = 1'b0;
			end
		endcase
	end

	// port address decode
	logic [2:0] addr;
	logic half_hi;
	hcpp_port_e port;

	always_comb begin
		addr = st_q.mux_mode ? st_q.mux_addr : port_select_i;
		half_hi = addr[`HCPP_ADDR_BYTE_BIT] ^ st_q.big_endian;
		if (addr[`HCPP_ADDR_FLAG_BIT]) begin
			port = HCPP_PORT_FLAG;
		end else if (!st_q.narrow && addr[`HCPP_ADDR_BYTE_BIT]) begin
			port = HCPP_PORT_NONE;
		end else if (addr[`HCPP_ADDR_DATA_BIT]) begin
			port = HCPP_PORT_DATA;
		end else begin
			port = HCPP_PORT_CMD;
		end
	end

	// flag byte as the host sees it
	logic [7:0] flag_byte;
	assign flag_byte = {`HCPP_FLAG_UNUSED, data_rx_enabled_i,
		st_q.fl_wdat, st_q.fl_cmd, st_q.fl_rdat, st_q.fl_stat};

	// next-state logic
	logic act;
	logic start;
	logic [1:0] bit_got;
	logic [15:0] rword;
	logic [15:0] wmerge;
	logic stat_done;
	logic rdat_done;
	logic cmd_done;
	logic wdat_done;

	always_comb begin
		st_d = st_q;
		act = 1'b0;
		start = 1'b0;
		bit_got = 2'h0;
		rword = 16'h0000;
		wmerge = 16'h0000;
		stat_done = 1'b0;
		rdat_done = 1'b0;
		cmd_done = 1'b0;
		wdat_done = 1'b0;
		if (clk_en_i) begin
			// straps are caught once, on the first enabled edge after reset
			if (!st_q.straps_taken) begin
				st_d.straps_taken = 1'b1;
				st_d.narrow = bus_width_strap_i;
				st_d.big_endian = byte_order_strap_i;
				st_d.irq_pol = irq_polarity_strap_i;
				st_d.itype = (iface_type_sel_i == `HCPP_TYPE_STORED) ?
					stored_iface_type_i : iface_type_sel_i;
				st_d.absent = (st_d.itype == `HCPP_TYPE_STORED) ||
					(st_d.itype == `HCPP_TYPE_RSVD);
				// generic and card types cannot run multiplexed
				st_d.mux_mode = ~bus_multiplex_strap_i &&
					(st_d.itype != `HCPP_TYPE_3) &&
					(st_d.itype != `HCPP_TYPE_6);
			end

			// address phase latch on the falling edge of the latch strobe
			st_d.latch_prev = latch;
			if (st_q.mux_mode && st_q.latch_prev && !latch) begin
				st_d.mux_addr = host_data_bus_i[2:0];
			end

			// one access per select/strobe assertion
			act = ~sel_n & (rd | wr) & st_q.straps_taken & ~st_q.absent;
			start = act & ~st_q.act;
			st_d.act = act;
			bit_got = half_hi ? `HCPP_GOT_HI : `HCPP_GOT_LO;

			if (!act) begin
				st_d.doe = 1'b0;
			end else if (start && rd && port != HCPP_PORT_NONE) begin
				// read: capture the answer once, hold it for the access
				case (port)
					HCPP_PORT_FLAG: rword = {flag_byte, flag_byte};
					HCPP_PORT_CMD: rword = st_q.status_word;
					HCPP_PORT_DATA: rword = st_q.rdata_word;
					default: rword = 16'h0000;
				endcase
				if (port == HCPP_PORT_FLAG) begin
					st_d.dout = rword;
				end else if (st_q.narrow) begin
					st_d.dout = {8'h00, half_hi ? rword[15:8] : rword[7:0]};
				end else begin
					st_d.dout = swap16(rword, st_q.big_endian);
				end
				st_d.doe = 1'b1;
				// pairing of byte reads, wide reads complete at once
				if (port == HCPP_PORT_CMD) begin
					st_d.stat_got = st_q.stat_got | bit_got;
					stat_done = !st_q.narrow ||
						(st_d.stat_got == `HCPP_GOT_BOTH);
				end else if (port == HCPP_PORT_DATA) begin
					st_d.rdat_got = st_q.rdat_got | bit_got;
					rdat_done = !st_q.narrow ||
						(st_d.rdat_got == `HCPP_GOT_BOTH);
				end
			end else if (start && wr) begin
				// write: flag port bits are all read-only, so it ignores them
				wmerge = swap16(host_data_bus_i, st_q.big_endian);
				if (port == HCPP_PORT_CMD) begin
					if (st_q.narrow) begin
						if (half_hi) begin
							st_d.cmd_word[15:8] = host_data_bus_i[7:0];
						end else begin
							st_d.cmd_word[7:0] = host_data_bus_i[7:0];
						end
						st_d.cmd_got = st_q.cmd_got | bit_got;
						cmd_done = st_d.cmd_got == `HCPP_GOT_BOTH;
					end else begin
						if (lane_lo) st_d.cmd_word[7:0] = wmerge[7:0];
						if (lane_hi) st_d.cmd_word[15:8] = wmerge[15:8];
						cmd_done = 1'b1;
					end
				end else if (port == HCPP_PORT_DATA) begin
					if (st_q.narrow) begin
						if (half_hi) begin
							st_d.wdat_word[15:8] = host_data_bus_i[7:0];
						end else begin
							st_d.wdat_word[7:0] = host_data_bus_i[7:0];
						end
						st_d.wdat_got = st_q.wdat_got | bit_got;
						wdat_done = st_d.wdat_got == `HCPP_GOT_BOTH;
					end else begin
						if (lane_lo) st_d.wdat_word[7:0] = wmerge[7:0];
						if (lane_hi) st_d.wdat_word[15:8] = wmerge[15:8];
						wdat_done = 1'b1;
					end
				end
				// flag port writes: no bit takes a value, upper lanes included
			end

			// pair trackers restart once a word is complete
			if (stat_done) st_d.stat_got = 2'h0;
			if (rdat_done) st_d.rdat_got = 2'h0;
			if (cmd_done) st_d.cmd_got = 2'h0;
			if (wdat_done) st_d.wdat_got = 2'h0;

			// flags: a set in the same cycle as a clear wins
			if (stat_done) st_d.fl_stat = 1'b0;
			if (status_load_i) begin
				st_d.status_word = status_word_i;
				st_d.fl_stat = 1'b1;
			end
			if (rdat_done) st_d.fl_rdat = 1'b0;
			if (rdata_load_i) begin
				st_d.rdata_word = rdata_word_i;
				st_d.fl_rdat = 1'b1;
			end
			if (cmd_taken_i) st_d.fl_cmd = 1'b0;
			if (cmd_done) st_d.fl_cmd = 1'b1;
			if (wdata_taken_i) st_d.fl_wdat = 1'b0;
			if (wdat_done) st_d.fl_wdat = 1'b1;

			// interrupt level from the next flags, polarity from strap
			st_d.irq = (st_d.fl_rdat | st_d.fl_stat) ~^ st_d.irq_pol;
			st_d.irq_oe = st_d.straps_taken & ~st_d.absent;
		end
	end

	// all state in one register; reset leaves pins released
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	// outputs straight from state flops
	assign host_data_bus_o = st_q.dout;
	assign host_data_bus_oe_o = st_q.doe;
	assign host_irq_o = st_q.irq;
	assign host_irq_oe_o = st_q.irq_oe;
	assign cmd_word_o = st_q.cmd_word;
	assign command_pending_o = st_q.fl_cmd;
	assign wdata_word_o = st_q.wdat_word;
	assign write_data_pending_o = st_q.fl_wdat;
	assign host_absent_o = st_q.absent;

endmodule : hcpp_top

`default_nettype wire

// ===== verif/hcpp_checker.sv
// assertions on the pins of the host cpu parallel port
`timescale 1ns/1ps
`default_nettype none

module hcpp_checker (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rstn_i,
	input wire logic clk_en_i,
	// host pins and straps
	input wire logic host_select_n_i,
	input wire logic [2:0] port_select_i,
	input wire logic [15:0] host_data_bus_o,
	input wire logic host_data_bus_oe_o,
	input wire logic host_irq_o,
	input wire logic host_irq_oe_o,
	input wire logic irq_polarity_strap_i,
	input wire logic bus_multiplex_strap_i,
	// core side
	input wire logic status_load_i,
	input wire logic rdata_load_i,
	input wire logic cmd_taken_i,
	input wire logic wdata_taken_i,
	input wire logic command_pending_o,
	input wire logic write_data_pending_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!rstn_i);
	logic fl_rd;
	// flag read held on a separate bus; mux mode ignores the address pins
	assign fl_rd = host_data_bus_oe_o && !host_select_n_i &&
		port_select_i[2] && bus_multiplex_strap_i;
	sel_gate_oe_a: assert property (
		host_select_n_i[*4] |-> !host_data_bus_oe_o)
		else $error("data bus driven with select high");
	flag_lanes_a: assert property (
		fl_rd |-> host_data_bus_o[15:8] == host_data_bus_o[7:0])
		else $error("flag lanes differ");
	flag_unused_a: assert property (
		fl_rd |-> host_data_bus_o[7:5] == 3'h0)
		else $error("unused flag bits set");
	stat_irq_a: assert property (
		status_load_i && clk_en_i && host_irq_oe_o |->
		##[1:2] host_irq_o == irq_polarity_strap_i)
		else $error("status load left irq idle");
	rdat_irq_a: assert property (
		rdata_load_i && clk_en_i && host_irq_oe_o |->
		##[1:2] host_irq_o == irq_polarity_strap_i)
		else $error("read data load left irq idle");
	irq_cause_a: assert property (
		$changed(host_irq_o) && $past(host_irq_oe_o) |->
		$past(status_load_i) || $past(status_load_i, 2) ||
		$past(rdata_load_i) || $past(rdata_load_i, 2) ||
		!$past(host_select_n_i, 2))
		else $error("irq moved without cause");
	cmd_clear_a: assert property (
		(host_select_n_i && clk_en_i)[*4] ##0 cmd_taken_i |->
		##[1:2] !command_pending_o)
		else $error("command pending not cleared");
	wdat_clear_a: assert property (
		(host_select_n_i && clk_en_i)[*4] ##0 wdata_taken_i |->
		##[1:2] !write_data_pending_o)
		else $error("write data pending not cleared");
	pend_set_a: assert property (
		$rose(command_pending_o) || $rose(write_data_pending_o) |->
		!$past(host_select_n_i, 2))
		else $error("pending flag set without access");
	// main scenarios reached
	cover property (fl_rd);
	cover property ($rose(command_pending_o));
	cover property (status_load_i ##2 host_irq_o == irq_polarity_strap_i);
endmodule : hcpp_checker

bind hcpp_top hcpp_checker chk_u (.clk_sys_i, .rstn_i, .clk_en_i,
	.host_select_n_i, .port_select_i, .host_data_bus_o,
	.host_data_bus_oe_o, .host_irq_o, .host_irq_oe_o,
	.irq_polarity_strap_i, .bus_multiplex_strap_i, .status_load_i,
	.rdata_load_i, .cmd_taken_i, .wdata_taken_i, .command_pending_o,
	.write_data_pending_o);

`default_nettype wire

// ===== verif/hcpp_host_model.sv
// host cpu model: generic four-strobe bus with pulled-up lines
`timescale 1ns/1ps
`default_nettype none

module hcpp_host_model (
	// clock
	input wire logic clk_sys_i,
	// bus towards the port
	output logic sel_n_o,
	output logic [2:0] addr_o,
	output logic [3:0] strb_n_o,
	output logic [15:0] bus_o,
	input wire logic [15:0] dout_i,
	input wire logic oe_i
);
	logic drv = 1'b0;
	logic [15:0] wd = 16'h0;
	// released lines float high through the pull-ups
	assign bus_o = drv ? wd : (oe_i ? dout_i : 16'hffff);
	initial begin
		sel_n_o = 1'b1;
		addr_o = 3'h0;
		strb_n_o = 4'hf;
	end
	// one access; strobes order wr_a, wr_b, rd_a, rd_b; b only when wide
	task automatic xfer(input logic wr, s, input logic [2:0] a,
		input logic [15:0] d, input logic w, output logic [15:0] q,
		output logic ok);
		int n;
		@(posedge clk_sys_i);
		#1 addr_o = a;
		wd = d;
		drv = wr;
		sel_n_o = s;
		strb_n_o = wr ? {1'b0, !w, 2'h3} : {2'h3, 1'b0, !w};
		repeat (4) @(posedge clk_sys_i);
		#1;
		// a slow answer is waited for, but never forever
		for (n = 0; n < 6 && !wr && oe_i !== 1'b1; n++) begin
			@(posedge clk_sys_i);
			#1;
		end
		q = dout_i;
		ok = wr || oe_i === 1'b1;
		sel_n_o = 1'b1;
		strb_n_o = 4'hf;
		drv = 1'b0;
		repeat (4) @(posedge clk_sys_i);
		#1;
	endtask : xfer
	// address phase of a multiplexed bus: address on the data lines while
	// the latch strobe (read b) falls, held long enough for the synchroniser
	task automatic latch(input logic [2:0] a);
		@(posedge clk_sys_i);
		#1 wd = {13'h0000, a};
		drv = 1'b1;
		repeat (2) @(posedge clk_sys_i);
		#1 strb_n_o[0] = 1'b0;
		repeat (4) @(posedge clk_sys_i);
		#1 drv = 1'b0;
		strb_n_o = 4'hf;
		repeat (2) @(posedge clk_sys_i);
		#1;
	endtask : latch
endmodule : hcpp_host_model

`default_nettype wire

// ===== verif/tb_host_cpu_parallel_port.sv
// self-checking bench for the host cpu parallel port
`timescale 1ns/1ps
`default_nettype none

module tb_host_cpu_parallel_port;
	logic clk_sys_i = 1'b0;
	logic rstn_i = 1'b0;
	logic clk_en_i = 1'b1;
	logic sel_n, rx_en, pol_s, big_s, nar_s, mux_s;
	logic oe, irq, irq_oe, cmd_p, wd_p, absent;
	logic [2:0] addr, tsel, tsto;
	logic [3:0] strb_n, ev;
	logic [15:0] bus_in, dout, stat_w, rdat_w, cmd_w, wdat_w;
	int bad_count = 0;
	int n_compared = 0;
	always #10 clk_sys_i = ~clk_sys_i;
	hcpp_host_model host_u (.clk_sys_i(clk_sys_i), .sel_n_o(sel_n),
		.addr_o(addr), .strb_n_o(strb_n), .bus_o(bus_in), .dout_i(dout),
		.oe_i(oe));
	hcpp_top dut_u (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
		.clk_en_i(clk_en_i), .host_select_n_i(sel_n), .port_select_i(addr),
		.host_data_bus_i(bus_in), .host_data_bus_o(dout),
		.host_data_bus_oe_o(oe), .write_strobe_a_n_i(strb_n[3]),
		.write_strobe_b_n_i(strb_n[2]), .read_strobe_a_n_i(strb_n[1]),
		.read_strobe_b_n_i(strb_n[0]), .host_irq_o(irq),
		.host_irq_oe_o(irq_oe), .iface_type_sel_i(tsel),
		.stored_iface_type_i(tsto), .bus_multiplex_strap_i(mux_s),
		.irq_polarity_strap_i(pol_s), .byte_order_strap_i(big_s),
		.bus_width_strap_i(nar_s), .cmd_word_o(cmd_w),
		.command_pending_o(cmd_p), .cmd_taken_i(ev[1]),
		.wdata_word_o(wdat_w), .write_data_pending_o(wd_p),
		.wdata_taken_i(ev[0]), .status_word_i(stat_w),
		.status_load_i(ev[3]), .rdata_word_i(rdat_w),
		.rdata_load_i(ev[2]), .data_rx_enabled_i(rx_en),
		.host_absent_o(absent));
	task automatic chk(input string nm, input logic [15:0] e, g);
		n_compared++;
		if (g !== e) begin
			$display("[ERR] %s expected %h seen %h", nm, e, g);
			bad_count++;
		end
	endtask : chk
	task automatic acc(input logic wr, s, input logic [2:0] a,
		input logic [15:0] d, input logic w, output logic [15:0] q);
		logic ok;
		host_u.xfer(wr, s, a, d, w, q, ok);
		chk("host answer", 16'h1, {15'h0, ok});
	endtask : acc
	task automatic flag(input logic [2:0] a, input logic [7:0] e);
		logic [15:0] q;
		acc(1'b0, 1'b0, a, 16'h0, !nar_s, q);
		chk("flag port", {e, e}, q);
	endtask : flag
	// core pulses: status load, read data load, cmd taken, data taken
	task automatic kick(input logic [3:0] m);
		@(posedge clk_sys_i);
		#1 ev = m;
		@(posedge clk_sys_i);
		#1 ev = 4'h0;
		repeat (2) @(posedge clk_sys_i);
		#1;
	endtask : kick
	// straps must be steady before release, they are taken once
	task automatic do_reset(input logic n, b, p,
		input logic [2:0] ts, so, input logic m, ab);
		rstn_i = 1'b0;
		nar_s = n;
		big_s = b;
		pol_s = p;
		tsel = ts;
		tsto = so;
		mux_s = m;
		repeat (16) @(posedge clk_sys_i);
		#1 rstn_i = 1'b1;
		repeat (3) @(posedge clk_sys_i);
		#1;
		chk("irq enable", {15'h0, !ab}, {15'h0, irq_oe});
		chk("irq idle", {15'h0, !p}, {15'h0, irq});
		chk("absent", {15'h0, ab}, {15'h0, absent});
	endtask : do_reset
	task automatic t_flags();
		rx_en = 1'b1;
		flag(3'h4, 8'h10);
		rx_en = 1'b0;
		flag(3'h6, 8'h00);
	endtask : t_flags
	task automatic t_write();
		logic [15:0] q;
		acc(1'b1, 1'b0, 3'h0, 16'h1234, 1'b1, q);
		chk("cmd word", 16'h1234, cmd_w);
		acc(1'b1, 1'b0, 3'h4, 16'hffff, 1'b1, q);
		flag(3'h4, 8'h04);
		kick(4'h2);
		chk("cmd pending", 16'h0, {15'h0, cmd_p});
		acc(1'b1, 1'b1, 3'h0, 16'h5555, 1'b1, q);
		chk("cmd kept", 16'h1234, cmd_w);
		flag(3'h4, 8'h00);
		acc(1'b1, 1'b0, 3'h2, 16'hbeef, 1'b1, q);
		chk("wdata word", 16'hbeef, wdat_w);
		flag(3'h4, 8'h08);
		kick(4'h1);
		chk("wdata pending", 16'h0, {15'h0, wd_p});
	endtask : t_write
	task automatic t_read();
		logic [15:0] q;
		// a frozen clock enable must swallow the status load
		clk_en_i = 1'b0;
		kick(4'h8);
		clk_en_i = 1'b1;
		flag(3'h4, 8'h00);
		stat_w = 16'ha55a;
		rdat_w = 16'h0ff0;
		kick(4'hc);
		flag(3'h4, 8'h03);
		acc(1'b0, 1'b0, 3'h0, 16'h0, 1'b1, q);
		chk("status word", 16'ha55a, q);
		chk("irq held", 16'h1, {15'h0, irq});
		acc(1'b0, 1'b0, 3'h2, 16'h0, 1'b1, q);
		chk("read data", 16'h0ff0, q);
		chk("irq cleared", 16'h0, {15'h0, irq});
	endtask : t_read
	// reserved type, and stored type 111, leave the host port dead
	task automatic t_absent();
		logic [15:0] q;
		do_reset(1'b0, 1'b0, 1'b1, 3'h4, 3'h3, 1'b1, 1'b1);
		acc(1'b1, 1'b0, 3'h0, 16'h1234, 1'b1, q);
		chk("absent cmd", 16'h0, {15'h0, cmd_p});
		do_reset(1'b0, 1'b0, 1'b1, 3'h7, 3'h7, 1'b1, 1'b1);
		acc(1'b1, 1'b0, 3'h2, 16'hbeef, 1'b1, q);
		chk("absent wdata", 16'h0, wdat_w);
	endtask : t_absent
	// multiplexed bus, type 0: latched address wins over the address pins
	task automatic t_mux();
		logic [15:0] q;
		do_reset(1'b0, 1'b0, 1'b1, 3'h0, 3'h3, 1'b0, 1'b0);
		host_u.latch(3'h0);
		acc(1'b1, 1'b0, 3'h4, 16'hc0de, 1'b1, q);
		chk("mux cmd word", 16'hc0de, cmd_w);
		chk("mux cmd pending", 16'h1, {15'h0, cmd_p});
		host_u.latch(3'h2);
		acc(1'b1, 1'b0, 3'h0, 16'h5a5a, 1'b1, q);
		chk("mux wdata word", 16'h5a5a, wdat_w);
	endtask : t_mux
	task automatic t_narrow();
		logic [15:0] q;
		// stored type 3 reached through type select 111
		do_reset(1'b1, 1'b1, 1'b0, 3'h7, 3'h3, 1'b1, 1'b0);
		acc(1'b1, 1'b0, 3'h1, 16'h0034, 1'b0, q);
		chk("half word", 16'h0, {15'h0, cmd_p});
		acc(1'b1, 1'b0, 3'h0, 16'h0012, 1'b0, q);
		chk("cmd word", 16'h1234, cmd_w);
		flag(3'h5, 8'h04);
		stat_w = 16'habcd;
		kick(4'h8);
		chk("irq low", 16'h0, {15'h0, irq});
		acc(1'b0, 1'b0, 3'h0, 16'h0, 1'b0, q);
		chk("status hi", 16'h00ab, q);
		chk("irq kept", 16'h0, {15'h0, irq});
		acc(1'b0, 1'b0, 3'h1, 16'h0, 1'b0, q);
		chk("status lo", 16'h00cd, q);
		chk("irq off", 16'h1, {15'h0, irq});
	endtask : t_narrow
	task automatic give_verdict();
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : give_verdict
	initial begin
		ev = 4'h0;
		rx_en = 1'b0;
		stat_w = 16'h0;
		rdat_w = 16'h0;
		do_reset(1'b0, 1'b0, 1'b1, 3'h3, 3'h3, 1'b1, 1'b0);
		t_flags();
		t_write();
		t_read();
		t_absent();
		t_mux();
		t_narrow();
		give_verdict();
	end
	// hang guard: a run this long counts as a mismatch
	initial begin
		repeat (20000) @(posedge clk_sys_i);
		bad_count++;
		give_verdict();
	end
endmodule : tb_host_cpu_parallel_port

`default_nettype wire
